// [core/pgr_pkg.sv]
// package for the gain and reference control block
package pgr_pkg;
    localparam logic [7:0] PGR_STATUS_ADDR = 8'h01;
    localparam logic [7:0] PGR_GAIN_ADDR = 8'h03;
    localparam logic [7:0] PGR_REFCTL_ADDR = 8'h05;
    localparam logic [7:0] PGR_IEXC1_ADDR = 8'h06;
    // gain register fields
    localparam int PGR_GAIN_LSB = 0;
    localparam int PGR_AMPEN_LSB = 3;
    // reference control fields
    localparam int PGR_INTERNAL_REF_POWER_LSB = 0;
    localparam int PGR_REF_SOURCE_SELECT_LSB = 2;
    localparam int PGR_NBUF_BIT = 4;
    localparam int PGR_PBUF_BIT = 5;
    // excitation register 1: rail detect enable bit
    localparam int PGR_RAILEN_BIT = 7;
    // status bit positions
    localparam int PGR_ST_REF1L = 0;
    localparam int PGR_ST_REF0L = 1;
    localparam int PGR_ST_NRAILN = 2;
    localparam int PGR_ST_NRAILP = 3;
    localparam int PGR_ST_PRAILN = 4;
    localparam int PGR_ST_PRAILP = 5;
    // reset values
    localparam logic [7:0] PGR_GAIN_RST = 8'h00;
    localparam logic [7:0] PGR_REFCTL_RST = 8'h00;
    localparam logic [7:0] PGR_IEXC1_RST = 8'h00;
    localparam logic [7:0] PGR_GVAL_RST = 8'h01;
    // amplifier enable and reference codes
    localparam logic [1:0] PGR_AMP_OFF = 2'h0;
    localparam logic [1:0] PGR_AMP_ON = 2'h1;
    localparam logic [1:0] PGR_REF_EXT0 = 2'h0;
    localparam logic [1:0] PGR_REF_EXT1 = 2'h1;
    localparam logic [1:0] PGR_REF_INT = 2'h2;
    localparam logic [1:0] PGR_REFPWR_OFF = 2'h0;
    localparam logic [1:0] PGR_REFPWR_SAVE = 2'h1;
    localparam logic [1:0] PGR_REFPWR_ON = 2'h2;
    localparam logic [2:0] PGR_GAIN_MAX_ANALOG = 3'h5;
    localparam int PGR_DATA_W = 24;
endpackage

// [core/pgr_scale.sv]
// digital gain scaling of conversion results
`timescale 1ns/1ps
module pgr_scale #(
    parameter int W = pgr_pkg::PGR_DATA_W
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [1:0] shift_i,
    input wire logic valid_i,
    input wire logic signed [W-1:0] data_i,
    output logic valid_o,
    output logic signed [W-1:0] data_o
);
    import pgr_pkg::*;
    logic valid_r;
    logic valid_nxt;
    logic signed [W-1:0] data_r;
    logic signed [W-1:0] data_nxt;

    always_comb begin
        valid_nxt = valid_i;
        data_nxt = data_r;
        if (valid_i) begin
            data_nxt = data_i <<< shift_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_r <= 1'b0;
            data_r <= '0;
        end else begin
            valid_r <= valid_nxt;
            data_r <= data_nxt;
        end
    end

    assign valid_o = valid_r;
    assign data_o = data_r;
endmodule

// [core/pgr_ctrl.sv]
// gain, amplifier enable and reference control with status flags
`timescale 1ns/1ps
//
// Contract
// - three-bit gain field decodes to gains 1 through 128.
// - enable code 00 powers down and bypasses amplifier; 01 enables it.
// - enabled gain 64 or 128 runs analog gain 32 plus digital scale.
// - four rail flags in status show amplifier outputs near rails.
// - rail detection runs only while rail-detect enable bit is set.
// - two-bit field selects internal or external reference; default pair 0.
// - select code 10 uses the internal reference.
// - power code 10 always on; 01 on but off in power-down.
// - internal reference stays off after reset until enabled.
// - reference buffer control bits are active low; 1 disables.
// - reference-low flags in status checked during every conversion.
module pgr_ctrl #(
    parameter int W = pgr_pkg::PGR_DATA_W
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic power_down_i,
    input wire logic converting_i,
    input wire logic pos_out_high_rail_i,
    input wire logic pos_out_low_rail_i,
    input wire logic neg_out_high_rail_i,
    input wire logic neg_out_low_rail_i,
    input wire logic ref0_low_i,
    input wire logic ref1_low_i,
    input wire logic conv_valid_i,
    input wire logic signed [W-1:0] conv_data_i,
    output logic conv_valid_o,
    output logic signed [W-1:0] conv_data_o,
    output logic [2:0] analog_gain_sel_o,
    output logic [7:0] gain_value_o,
    output logic amp_power_o,
    output logic amp_bypass_o,
    output logic rail_detect_on_o,
    output logic [1:0] ref_source_select_o,
    output logic use_internal_ref_o,
    output logic internal_ref_power_o,
    output logic pos_ref_buffer_on_o,
    output logic neg_ref_buffer_on_o
);
    import pgr_pkg::*;

    // configuration registers
    logic [7:0] gain_r;
    logic [7:0] gain_nxt;
    logic [7:0] refctl_r;
    logic [7:0] refctl_nxt;
    logic [7:0] iexc1_r;
    logic [7:0] iexc1_nxt;
    // two-flop synchronisers
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic pd_s1_r;
    logic pd_s2_r;
    logic cv_s1_r;
    logic cv_s2_r;
    // status flags, derived controls, read data
    logic [5:0] flags_r;
    logic [5:0] flags_nxt;
    logic [7:0] outs_nxt;
    logic [7:0] outs_r;
    logic [1:0] shift_nxt;
    logic [1:0] shift_r;
    logic [2:0] ana_nxt;
    logic [2:0] ana_r;
    logic [7:0] gval_nxt;
    logic [7:0] gval_r;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;

    function automatic logic [7:0] gain_decode(input logic [2:0] code);
        gain_decode = 8'h01 << code;
    endfunction

    logic [2:0] gcode;
    logic [1:0] amp_en;
    logic [1:0] refpwr;
    logic rail_en;
    logic [1:0] ref_source_select;
    assign gcode = gain_r[PGR_GAIN_LSB +: 3];
    assign ref_source_select = refctl_r[PGR_REF_SOURCE_SELECT_LSB +: 2];
    assign amp_en = gain_r[PGR_AMPEN_LSB +: 2];
    assign refpwr = refctl_r[PGR_INTERNAL_REF_POWER_LSB +: 2];
    assign rail_en = iexc1_r[PGR_RAILEN_BIT];

    // register writes
    always_comb begin
        gain_nxt = gain_r;
        refctl_nxt = refctl_r;
        iexc1_nxt = iexc1_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                PGR_GAIN_ADDR: gain_nxt = reg_wdata_i;
                PGR_REFCTL_ADDR: refctl_nxt = reg_wdata_i;
                PGR_IEXC1_ADDR: iexc1_nxt = reg_wdata_i;
                default: gain_nxt = gain_r;
            endcase
        end
    end

    // status flags follow the monitors
    always_comb begin
        flags_nxt = '0;
        if (rail_en) begin
            flags_nxt[5:2] = sync2_r[5:2];
        end
        if (cv_s2_r) begin
            flags_nxt[1:0] = sync2_r[1:0];
        end else begin
            flags_nxt[1:0] = flags_r[1:0];
        end
    end

    // derived controls
    always_comb begin
        shift_nxt = 2'h0;
        ana_nxt = gcode;
        gval_nxt = gain_decode(gcode);
        if (amp_en == PGR_AMP_ON && gcode > PGR_GAIN_MAX_ANALOG) begin
            ana_nxt = PGR_GAIN_MAX_ANALOG;
            shift_nxt = 2'(gcode - PGR_GAIN_MAX_ANALOG);
        end
        outs_nxt[0] = (amp_en == PGR_AMP_ON);
        outs_nxt[1] = (amp_en == PGR_AMP_OFF);
        outs_nxt[2] = rail_en && (amp_en == PGR_AMP_ON);
        outs_nxt[3] = (ref_source_select == PGR_REF_INT);
        outs_nxt[4] = (refpwr == PGR_REFPWR_ON) ||
                      (refpwr == PGR_REFPWR_SAVE && !pd_s2_r);
        outs_nxt[5] = !refctl_r[PGR_PBUF_BIT];
        outs_nxt[6] = !refctl_r[PGR_NBUF_BIT];
        outs_nxt[7] = 1'b0;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_r <= PGR_GAIN_RST;
            refctl_r <= PGR_REFCTL_RST;
            iexc1_r <= PGR_IEXC1_RST;
            sync1_r <= '0;
            sync2_r <= '0;
            pd_s1_r <= 1'b0;
            pd_s2_r <= 1'b0;
            cv_s1_r <= 1'b0;
            cv_s2_r <= 1'b0;
            flags_r <= '0;
            outs_r <= '0;
            shift_r <= '0;
            ana_r <= '0;
            gval_r <= PGR_GVAL_RST;
            rdata_r <= '0;
        end else begin
            gain_r <= gain_nxt;
            refctl_r <= refctl_nxt;
            iexc1_r <= iexc1_nxt;
            sync1_r <= {pos_out_high_rail_i, pos_out_low_rail_i,
                        neg_out_high_rail_i, neg_out_low_rail_i,
                        ref0_low_i, ref1_low_i};
            sync2_r <= sync1_r;
            pd_s1_r <= power_down_i;
            pd_s2_r <= pd_s1_r;
            cv_s1_r <= converting_i;
            cv_s2_r <= cv_s1_r;
            flags_r <= flags_nxt;
            outs_r <= outs_nxt;
            shift_r <= shift_nxt;
            ana_r <= ana_nxt;
            gval_r <= gval_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // read data selection, registered
    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_addr_i)
            PGR_STATUS_ADDR: begin
                rdata_nxt[PGR_ST_PRAILP] = flags_r[5];
                rdata_nxt[PGR_ST_PRAILN] = flags_r[4];
                rdata_nxt[PGR_ST_NRAILP] = flags_r[3];
                rdata_nxt[PGR_ST_NRAILN] = flags_r[2];
                rdata_nxt[PGR_ST_REF0L] = flags_r[1];
                rdata_nxt[PGR_ST_REF1L] = flags_r[0];
            end
            PGR_GAIN_ADDR: rdata_nxt = gain_r;
            PGR_REFCTL_ADDR: rdata_nxt = refctl_r;
            PGR_IEXC1_ADDR: rdata_nxt = iexc1_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    pgr_scale #(.W(W)) u_scale (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .shift_i(shift_r),
        .valid_i(conv_valid_i),
        .data_i(conv_data_i),
        .valid_o(conv_valid_o),
        .data_o(conv_data_o)
    );

    // output drive
    assign reg_rdata_o = rdata_r;
    assign analog_gain_sel_o = ana_r;
    assign gain_value_o = gval_r;
    assign amp_power_o = outs_r[0];
    assign amp_bypass_o = outs_r[1];
    assign rail_detect_on_o = outs_r[2];
    assign ref_source_select_o = ref_source_select;
    assign use_internal_ref_o = outs_r[3];
    assign internal_ref_power_o = outs_r[4];
    assign pos_ref_buffer_on_o = outs_r[5];
    assign neg_ref_buffer_on_o = outs_r[6];
endmodule

// [dv/pgr_ctrl_checker.sv]
// assertions on the ports of the gain and reference control block
`timescale 1ns/1ps
module pgr_ctrl_checker #(
    parameter int W = 24
) (
    input wire logic mclk_i, rst_i, reg_wr_i, converting_i, ref0_low_i,
    input wire logic pos_out_high_rail_i, conv_valid_i, conv_valid_o,
    input wire logic [7:0] reg_addr_i, reg_rdata_o, gain_value_o,
    input wire logic signed [W-1:0] conv_data_i, conv_data_o,
    input wire logic [2:0] analog_gain_sel_o,
    input wire logic [1:0] ref_source_select_o,
    input wire logic amp_power_o, amp_bypass_o, rail_detect_on_o,
    input wire logic use_internal_ref_o, internal_ref_power_o,
    input wire logic pos_ref_buffer_on_o, neg_ref_buffer_on_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // register quietly addressed for two cycles
    wire q3 = reg_addr_i == 8'h03 && !reg_wr_i;
    wire q5 = reg_addr_i == 8'h05 && !reg_wr_i;
    logic q3_r, q5_r;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q3_r <= 1'b0;
            q5_r <= 1'b0;
        end else begin
            q3_r <= q3;
            q5_r <= q5;
        end
    end
    wire g3 = q3 && q3_r;
    wire g5 = q5 && q5_r;
    wire [1:0] sh = !amp_power_o ? 2'h0 :
        gain_value_o[7] ? 2'h2 : {1'b0, gain_value_o[6]};
    sequence s_rail_high;
        (pos_out_high_rail_i && rail_detect_on_o) [*4];
    endsequence
    sequence s_ref_low;
        (converting_i && ref0_low_i) [*4];
    endsequence
    a_gain_decode: assert property (g3 |->
        gain_value_o == 8'h01 << reg_rdata_o[2:0]) else $error("gain");
    a_amp_enable: assert property (g3 |->
        amp_power_o == (reg_rdata_o[4:3] == 2'h1) &&
        amp_bypass_o == (reg_rdata_o[4:3] == 2'h0)) else $error("amp");
    a_analog_cap: assert property (g3 && reg_rdata_o[4:3] == 2'h1 &&
        reg_rdata_o[2:0] > 3'h5 |-> analog_gain_sel_o == 3'h5)
        else $error("cap");
    a_scale_result: assert property (conv_valid_i |=> conv_valid_o &&
        conv_data_o == $past(conv_data_i) <<< $past(sh)) else $error("scale");
    a_rail_flag: assert property (s_rail_high |=>
        $past(reg_addr_i) != 8'h01 || reg_rdata_o[5]) else $error("rail");
    a_ref_select: assert property (g5 |->
        use_internal_ref_o == (reg_rdata_o[3:2] == 2'h2) &&
        ref_source_select_o == reg_rdata_o[3:2]) else $error("ref_source_select");
    a_ref_power: assert property (g5 && reg_rdata_o[1:0] != 2'h1 |->
        internal_ref_power_o == (reg_rdata_o[1:0] == 2'h2))
        else $error("refpwr");
    a_buf_polarity: assert property (g5 |->
        pos_ref_buffer_on_o == !reg_rdata_o[5] &&
        neg_ref_buffer_on_o == !reg_rdata_o[4]) else $error("buf");
    a_ref_low: assert property (s_ref_low |=>
        $past(reg_addr_i) != 8'h01 || reg_rdata_o[1]) else $error("reflow");
endmodule

// [dv/tb.sv]
// self-checking testbench for the gain and reference control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
    import pgr_pkg::*;
    localparam int W = 24;
    logic mclk_i = 0, rst_i = 1, reg_wr_i = 0, power_down_i = 0;
    logic converting_i = 0, conv_valid_i = 0, ref0_low_i = 0, ref1_low_i = 0;
    logic pos_out_high_rail_i = 0, pos_out_low_rail_i = 0;
    logic neg_out_high_rail_i = 0, neg_out_low_rail_i = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, d, reg_rdata_o, gain_value_o;
    logic signed [W-1:0] conv_data_i = 0, conv_data_o;
    logic conv_valid_o, amp_power_o, amp_bypass_o, rail_detect_on_o;
    logic use_internal_ref_o, internal_ref_power_o;
    logic pos_ref_buffer_on_o, neg_ref_buffer_on_o;
    logic [2:0] analog_gain_sel_o;
    logic [1:0] ref_source_select_o, b;
    int n_errors = 0, tests_run = 0;
    pgr_ctrl #(.W(W)) pgr_ctrl_inst (.mclk_i, .rst_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rdata_o, .power_down_i, .converting_i,
        .pos_out_high_rail_i, .pos_out_low_rail_i, .neg_out_high_rail_i,
        .neg_out_low_rail_i, .ref0_low_i, .ref1_low_i, .conv_valid_i,
        .conv_data_i, .conv_valid_o, .conv_data_o, .analog_gain_sel_o,
        .gain_value_o, .amp_power_o, .amp_bypass_o, .rail_detect_on_o,
        .ref_source_select_o, .use_internal_ref_o, .internal_ref_power_o,
        .pos_ref_buffer_on_o, .neg_ref_buffer_on_o);
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        tick(1);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1;
        tick(1);
        reg_wr_i = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, string n);
        reg_addr_i = a;
        tick(1);
        `CHK(n, e, reg_rdata_o)
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        give_verdict();
    end
    initial begin
        tick(5);
        rst_i = 0;
        rd(8'h03, 8'h00, "gain rst");
        rd(8'h05, 8'h00, "ref rst");
        rd(8'h06, 8'h00, "exc rst");
        `CHK("ref off", 1'b0, internal_ref_power_o)
        `CHK("ref sel", 2'h0, ref_source_select_o)
        for (int g = 0; g < 8; g++) begin
            wr(8'h03, 8'h08 | 8'(g));
            rd(8'h03, 8'h08 | 8'(g), "gain reg");
            `CHK("gain", 8'h01 << g, gain_value_o)
            `CHK("analog", (g > 5) ? 3'h5 : 3'(g), analog_gain_sel_o)
            `CHK("amp on", 1'b1, amp_power_o)
            conv_data_i = -24'sd3;
            conv_valid_i = 1;
            tick(1);
            conv_valid_i = 0;
            `CHK("valid", 1'b1, conv_valid_o)
            `CHK("scaled", -24'sd3 <<< (g > 5 ? g - 5 : 0), conv_data_o)
        end
        wr(8'h03, 8'h00);
        rd(8'h03, 8'h00, "gain reg");
        `CHK("bypass", 2'h2, {amp_bypass_o, amp_power_o})
        for (int i = 0; i < 9; i++) begin
            power_down_i = i[0];
            b = (i > 5) ? 2'h3 : 2'(i);
            d = {2'h0, b, 2'(i / 3), 2'(i % 3)};
            wr(8'h05, d);
            rd(8'h05, d, "ref reg");
            tick(2);
            `CHK("sel", 2'(i / 3), ref_source_select_o)
            `CHK("int", i / 3 == 2, use_internal_ref_o)
            `CHK("pwr", i % 3 == 2 || i == 4, internal_ref_power_o)
            `CHK("pbuf", !b[1], pos_ref_buffer_on_o)
            `CHK("nbuf", !b[0], neg_ref_buffer_on_o)
        end
        wr(8'h01, 8'hff);
        rd(8'h01, 8'h00, "status ro");
        wr(8'h7f, 8'h55);
        rd(8'h7f, 8'h00, "unmapped");
        wr(8'h05, 8'h00);
        wr(8'h03, 8'h08);
        wr(8'h06, 8'h80);
        rd(8'h06, 8'h80, "exc reg");
        `CHK("rail on", 1'b1, rail_detect_on_o)
        pos_out_high_rail_i = 1;
        neg_out_high_rail_i = 1;
        ref0_low_i = 1;
        converting_i = 1;
        tick(5);
        rd(8'h01, 8'h2a, "flags");
        pos_out_high_rail_i = 0;
        neg_out_high_rail_i = 0;
        pos_out_low_rail_i = 1;
        neg_out_low_rail_i = 1;
        ref1_low_i = 1;
        tick(5);
        rd(8'h01, 8'h17, "low flags");
        wr(8'h06, 8'h00);
        tick(4);
        rd(8'h01, 8'h03, "rail off");
        `CHK("rail det", 1'b0, rail_detect_on_o)
        converting_i = 0;
        tick(4);
        ref0_low_i = 0;
        ref1_low_i = 0;
        tick(5);
        rd(8'h01, 8'h03, "ref hold");
        converting_i = 1;
        tick(5);
        rd(8'h01, 8'h00, "ref clear");
        give_verdict();
    end
endmodule
bind pgr_ctrl pgr_ctrl_checker #(.W(W)) pgr_ctrl_checker_inst (.mclk_i,
    .rst_i, .reg_wr_i, .converting_i, .ref0_low_i, .pos_out_high_rail_i,
    .conv_valid_i, .conv_valid_o, .reg_addr_i, .reg_rdata_o, .gain_value_o,
    .conv_data_i, .conv_data_o, .analog_gain_sel_o, .ref_source_select_o,
    .amp_power_o, .amp_bypass_o, .rail_detect_on_o, .use_internal_ref_o,
    .internal_ref_power_o, .pos_ref_buffer_on_o, .neg_ref_buffer_on_o);
